// *** common/ppp_pkg.sv ***
// constants, carriers and states of the parallel peripheral port
// assumes a 125 MHz system clock and host pins already at logic level
package ppp_pkg;
    localparam int CLK_MHZ    = 125;
    localparam int ACK_NS     = 2000;
    localparam int ACK_CYC    = (ACK_NS * CLK_MHZ) / 1000;
    localparam int INIT_NS    = 50000;
    localparam int INIT_CYC   = (INIT_NS * CLK_MHZ + 999) / 1000;
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 16;

    localparam logic [7:0] SEL_CODE   = 8'h11;
    localparam logic [7:0] DESEL_CODE = 8'h13;
    localparam logic [7:0] EXT_NIBBLE = 8'h00;

    // host pins as seen after synchronisation
    typedef struct packed {
        logic       strobe_n;
        logic       init_n;
        logic       sel_in;
        logic       active;
        logic       host_busy;
        logic [7:0] data;
    } host_in_t;
    localparam host_in_t HOST_IN_RST = 13'h1900;

    // status pins, forward meaning / reverse meaning
    typedef struct packed {
        logic ack_ptr_clk;
        logic busy_bit3;
        logic pe_bit2;
        logic slct_bit1;
        logic err_bit0;
        logic logic_high;
    } pin_out_t;
    localparam pin_out_t PIN_OUT_RST = 6'h32;

    typedef enum logic [2:0] {
        F_IDLE = 3'h1,
        F_PUSH = 3'h2,
        F_ACK  = 3'h4
    } fwd_state_t;

    typedef enum logic [6:0] {
        R_OFF    = 7'h01,
        R_NEG    = 7'h02,
        R_NEGACK = 7'h04,
        R_IDLE   = 7'h08,
        R_SET    = 7'h10,
        R_LOW    = 7'h20,
        R_HIGH   = 7'h40
    } rev_state_t;
endpackage

// *** rtl/ppp_fifo.sv ***
// synchronous fifo, power-of-two depth
// assumes one clock; clear empties it in one cycle
`timescale 1ns/1ps
module ppp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         clear,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    always_comb begin
        in_ready  = cnt_q != (AW+1)'(DEPTH);
        out_valid = cnt_q != '0;
        out_data  = mem_q[rd_q];
        push      = in_valid & in_ready;
        pop       = out_valid & out_ready;
        wr_d      = wr_q + AW'(push);
        rd_d      = rd_q + AW'(pop);
        cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (clear) begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule

// *** rtl/ppp_device.sv ***
// printer-side logic of a bidirectional parallel port
// assumes host pins are plain levels; forward bytes drain to the printer
`timescale 1ns/1ps
module ppp_device
    import ppp_pkg::*;
#(
    parameter int DEPTH       = FIFO_DEPTH,
    parameter int INIT_CYCLES = INIT_CYC
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // host pins
    input  wire host_in_t          host_in,
    output pin_out_t               pins,
    // printer status
    input  wire logic              paper_out,
    input  wire logic              prn_error,
    input  wire logic              prn_offline,
    output logic                   prn_reset,
    // forward bytes to printer
    output logic                   prn_valid,
    input  wire logic              prn_ready,
    output logic [DATA_W-1:0]      prn_data,
    // reverse bytes from printer
    input  wire logic              rev_valid,
    input  wire logic [DATA_W-1:0] rev_data,
    output logic                   rev_taken
);
    localparam int IW = $clog2(INIT_CYCLES + 1);

    function automatic logic [3:0] nibble(input logic [7:0] b, input logic hi);
        return hi ? b[7:4] : b[3:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronisers and init filter
    host_in_t    meta_q, sync_q, prev_q;
    logic [IW-1:0] icnt_q, icnt_d;
    logic        srst;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= HOST_IN_RST;
            sync_q <= HOST_IN_RST;
            prev_q <= HOST_IN_RST;
        end else begin
            meta_q <= host_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    always_comb begin
        icnt_d = '0;
        if (!sync_q.init_n) begin
            icnt_d = (icnt_q == IW'(INIT_CYCLES)) ? icnt_q : icnt_q + IW'(1);
        end
        srst = icnt_q == IW'(INIT_CYCLES);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            icnt_q <= '0;
        end else begin
            icnt_q <= icnt_d;
        end
    end

    logic strobe_fall, hclk_rise, err_any;
    assign strobe_fall = prev_q.strobe_n & ~sync_q.strobe_n;
    assign hclk_rise   = ~prev_q.strobe_n & sync_q.strobe_n;
    assign err_any     = paper_out | prn_error;

    ////////////////////////////////////////////////////////////////////////
    // forward channel
    fwd_state_t  fwd_q, fwd_d;
    rev_state_t  rev_q, rev_d;
    logic [7:0]  cnt_q, cnt_d, latch_q, latch_d;
    logic        sel_q, sel_d, push, fifo_ready;

    always_comb begin
        fwd_d   = fwd_q;
        cnt_d   = cnt_q;
        sel_d   = sel_q;
        latch_d = latch_q;
        push    = 1'b0;
        case (fwd_q)
            F_IDLE: begin
                if (rev_q == R_OFF && strobe_fall) begin
                    latch_d = sync_q.data;
                    fwd_d   = F_PUSH;
                end
            end
            F_PUSH: begin
                if (fifo_ready) begin
                    push  = 1'b1;
                    cnt_d = '0;
                    fwd_d = F_ACK;
                    if (sync_q.sel_in && latch_q == SEL_CODE) begin
                        sel_d = 1'b1;
                    end
                    if (sync_q.sel_in && latch_q == DESEL_CODE) begin
                        sel_d = 1'b0;
                    end
                end
            end
            F_ACK: begin
                if (cnt_q == 8'(ACK_CYC - 1)) begin
                    fwd_d = F_IDLE;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end
            default: fwd_d = F_IDLE;
        endcase
        if (srst) begin
            fwd_d = F_IDLE;
            sel_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fwd_q   <= F_IDLE;
            cnt_q   <= 8'h00;
            sel_q   <= 1'b1;
            latch_q <= 8'h00;
        end else begin
            fwd_q   <= fwd_d;
            cnt_q   <= cnt_d;
            sel_q   <= sel_d;
            latch_q <= latch_d;
        end
    end

    ppp_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .clear     (srst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (latch_q),
        .out_valid (prn_valid),
        .out_ready (prn_ready),
        .out_data  (prn_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // reverse channel, nibble mode
    logic [7:0] byte_q, byte_d;
    logic       hi_q, hi_d, ok_q, ok_d, take_d;

    always_comb begin
        rev_d  = rev_q;
        byte_d = byte_q;
        hi_d   = hi_q;
        ok_d   = ok_q;
        take_d = 1'b0;
        case (rev_q)
            R_OFF:    if (sync_q.active) rev_d = R_NEG;
            R_NEG:    if (!sync_q.host_busy) rev_d = R_NEGACK;
            R_NEGACK: begin
                if (hclk_rise) begin
                    ok_d  = sync_q.data == EXT_NIBBLE;
                    rev_d = R_IDLE;
                end
            end
            R_IDLE: begin
                if (ok_q && rev_valid && !sync_q.host_busy) begin
                    byte_d = rev_data;
                    take_d = 1'b1;
                    hi_d   = 1'b0;
                    rev_d  = R_SET;
                end
            end
            R_SET:    rev_d = R_LOW;
            R_LOW:    if (sync_q.host_busy) rev_d = R_HIGH;
            R_HIGH: begin
                if (hi_q) begin
                    rev_d = R_IDLE;
                end else if (!sync_q.host_busy) begin
                    hi_d  = 1'b1;
                    rev_d = R_SET;
                end
            end
            default: rev_d = R_OFF;
        endcase
        if (!sync_q.active || srst) begin
            rev_d = R_OFF;
            ok_d  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rev_q     <= R_OFF;
            byte_q    <= 8'h00;
            hi_q      <= 1'b0;
            ok_q      <= 1'b0;
            rev_taken <= 1'b0;
        end else begin
            rev_q     <= rev_d;
            byte_q    <= byte_d;
            hi_q      <= hi_d;
            ok_q      <= ok_d;
            rev_taken <= take_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers
    pin_out_t   pins_d;
    logic [3:0] nib;

    always_comb begin
        nib = nibble(byte_q, hi_q);
        pins_d.busy_bit3   = fwd_q != F_IDLE || prn_offline || err_any;
        pins_d.ack_ptr_clk = fwd_q != F_ACK;
        pins_d.pe_bit2     = paper_out;
        pins_d.slct_bit1   = sel_q & ~err_any;
        pins_d.err_bit0    = ~err_any;
        pins_d.logic_high  = sync_q.active;
        if (rev_q != R_OFF) begin
            pins_d.ack_ptr_clk = !(rev_q == R_NEGACK || rev_q == R_LOW);
            pins_d.busy_bit3   = err_any;
            pins_d.pe_bit2     = (rev_q == R_NEGACK) | rev_valid;
            pins_d.slct_bit1   = (rev_q == R_NEGACK) | ok_q;
            pins_d.err_bit0    = ~(rev_valid & ok_q);
            if (rev_q == R_SET || rev_q == R_LOW || rev_q == R_HIGH) begin
                {pins_d.busy_bit3, pins_d.pe_bit2, pins_d.slct_bit1, pins_d.err_bit0} = nib;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins      <= PIN_OUT_RST;
            prn_reset <= 1'b0;
        end else begin
            pins      <= pins_d;
            prn_reset <= srst;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_INIT_RESET: assert property (srst |=> fwd_q == F_IDLE && rev_q == R_OFF && prn_reset)
        else $error("init did not reset the port");
    AST_ERR_PIN: assert property (rev_q == R_OFF && rev_d == R_OFF && err_any |=> !pins.err_bit0)
        else $error("error pin not low on error");
    AST_SEL_GATED: assert property (!sync_q.sel_in && !srst |=> $stable(sel_q))
        else $error("select changed without select-in");
    AST_ACK_LEN: assert property ($fell(fwd_q == F_ACK) && !$past(srst) |-> $past(cnt_q) == 8'(ACK_CYC - 1))
        else $error("acknowledge pulse length wrong");
    AST_BUSY_ENTRY: assert property (fwd_q != F_IDLE && rev_q == R_OFF |=> pins.busy_bit3)
        else $error("busy low during byte entry");
    AST_NIBBLE: assert property (rev_q == R_LOW |=> {pins.busy_bit3, pins.pe_bit2, pins.slct_bit1,
            pins.err_bit0} == nibble($past(byte_q), $past(hi_q)) || rev_q == R_OFF)
        else $error("nibble bits mismatch");
    AST_PTR_CLK: assert property (rev_q == R_SET ##1 rev_q == R_LOW |=> !pins.ack_ptr_clk)
        else $error("printer clock not low for nibble");
    AST_HOST_PACE: assert property (rev_q == R_LOW && !sync_q.host_busy && sync_q.active && !srst
            |=> rev_q == R_LOW)
        else $error("nibble advanced without host");
    AST_LOGIC_H: assert property (sync_q.active |=> pins.logic_high)
        else $error("logic high not driven");
    AST_ACTIVE_ONLY: assert property (!sync_q.active |=> rev_q == R_OFF)
        else $error("reverse state without active");
    AST_SYNC_EDGE: assert property ($rose(fwd_q == F_PUSH) |-> $past(strobe_fall) && !$past(meta_q.strobe_n, 2))
        else $error("strobe edge not from synced pin");

    COV_FWD_BYTE: cover property (fwd_q == F_PUSH ##1 fwd_q == F_ACK);
    COV_NEG_OK: cover property (rev_q == R_NEGACK ##1 rev_q == R_IDLE && ok_q);
    COV_REV_BYTE: cover property (rev_q == R_HIGH && hi_q ##1 rev_q == R_IDLE);
    COV_INIT: cover property ($rose(srst));
endmodule

// *** bench/ppp_host_model.sv ***
// host-side parallel port controller model
// assumes the device clock; tasks are called by the bench
`timescale 1ns/1ps
module ppp_host_model
    import ppp_pkg::*;
(
    // clock
    input  wire logic     clk,
    // port pins
    output host_in_t      h,
    input  wire pin_out_t p
);
    initial h = HOST_IN_RST;
    ////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // bounded wait for ptr clock (bsy 0) or busy (bsy 1)
    task automatic wait_for(input logic bsy, input logic lvl, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 1000 && !ok; i++) begin
            @(posedge clk);
            ok = ((bsy ? p.busy_bit3 : p.ack_ptr_clk) === lvl);
        end
    endtask
    task automatic set_sel(input logic v);
        h.sel_in <= v;
        tick(1);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ok);
        h.data <= b;
        tick(1);
        h.strobe_n <= 1'b0;
        tick(64);
        h.strobe_n <= 1'b1;
        wait_for(1'b1, 1'b0, ok);
        h.data <= ~b;
        tick(1);
    endtask
    task automatic init_pulse(input int n);
        h.init_n <= 1'b0;
        tick(n);
        h.init_n <= 1'b1;
        tick(1);
    endtask
    task automatic negotiate(input logic [7:0] req, output logic ok);
        logic o;
        h.data <= req;
        h.active <= 1'b1;
        tick(2);
        h.host_busy <= 1'b0;
        wait_for(1'b0, 1'b0, ok);
        h.strobe_n <= 1'b0;
        tick(4);
        h.strobe_n <= 1'b1;
        wait_for(1'b0, 1'b1, o);
        h.host_busy <= 1'b1;
        h.data <= 8'hFF;
        ok = ok & o;
        tick(1);
    endtask
    // two nibble handshakes, low nibble first
    task automatic read_byte(output logic [7:0] b, output logic ok);
        logic o;
        ok = 1'b1;
        for (int n = 0; n < 2; n++) begin
            h.host_busy <= 1'b0;
            wait_for(1'b0, 1'b0, o);
            ok = ok & o;
            b[4*n +: 4] = {p.busy_bit3, p.pe_bit2, p.slct_bit1, p.err_bit0};
            h.host_busy <= 1'b1;
            wait_for(1'b0, 1'b1, o);
            ok = ok & o;
        end
        tick(1);
    endtask
    task automatic leave();
        h.active <= 1'b0;
        tick(6);
    endtask
endmodule

// *** bench/tb_ppp_device.sv ***
// bench for the parallel peripheral port
// assumes the host model drives all host pins
`timescale 1ns/1ps
module tb_ppp_device;
    import ppp_pkg::*;
    logic       clk, resetn, paper_out, prn_error, prn_offline;
    logic       prn_ready, rev_valid, prn_reset, prn_valid, rev_taken, ok, saw_rst;
    logic [7:0] rev_data, prn_data, b;
    host_in_t   host_in;
    pin_out_t   pins;
    int         num_errors = 0;
    int         checks_done = 0;
    int         run = 0;
    int         last_ack = 0;
    int         n_taken = 0;
    logic [7:0] got[$];
    ppp_device #(.INIT_CYCLES(8)) dut (.clk(clk), .resetn(resetn), .host_in(host_in), .pins(pins),
        .paper_out(paper_out), .prn_error(prn_error), .prn_offline(prn_offline), .prn_reset(prn_reset),
        .prn_valid(prn_valid), .prn_ready(prn_ready), .prn_data(prn_data), .rev_valid(rev_valid),
        .rev_data(rev_data), .rev_taken(rev_taken));
    ppp_host_model host (.clk(clk), .h(host_in), .p(pins));
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (prn_valid === 1'b1 && prn_ready) got.push_back(prn_data);
        if (prn_reset === 1'b1) saw_rst <= 1'b1;
        if (rev_taken === 1'b1) begin
            rev_valid <= 1'b0;
            n_taken <= n_taken + 1;
        end
        if (pins.ack_ptr_clk === 1'b0) run <= run + 1;
        else if (run != 0) begin
            last_ack <= run;
            run <= 0;
        end
    end
    task automatic check(input logic c, input string msg);
        checks_done++;
        if (c !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_status();
        logic [2:0] s;
        for (int i = 0; i < 4; i++) begin
            s = 3'(4 >> i);
            {paper_out, prn_error, prn_offline} <= s;
            host.tick(6);
            check(pins.err_bit0 === (s[2:1] == 2'b00), "error pin");
            check(pins.busy_bit3 === (s != 3'b000), "busy on paper/error/offline");
            check(pins.pe_bit2 === s[2] && pins.slct_bit1 === (s[2:1] == 2'b00), "paper/select pin");
        end
        check(pins.pe_bit2 === 1'b0, "paper pin");
    endtask
    task automatic t_fifo();
        prn_ready <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            host.send_byte({i[3:0], ~i[3:0]}, ok);
            check(ok && last_ack == ACK_CYC, "ack width");
        end
        host.send_byte(8'hFF, ok);
        check(!ok && pins.busy_bit3 === 1'b1, "full stall busy");
        prn_ready <= 1'b1;
        host.wait_for(1'b1, 1'b0, ok);
        check(ok && got.size() == 17, "drain count");
        for (int i = 0; i < 16; i++) check(got[i] === {i[3:0], ~i[3:0]}, "drain data");
        check(got[16] === 8'hFF, "last byte");
    endtask
    task automatic t_select();
        logic       sv[5] = '{1, 0, 1, 0, 1};
        logic [7:0] cd[5] = '{DESEL_CODE, SEL_CODE, SEL_CODE, DESEL_CODE, DESEL_CODE};
        logic       ex[5] = '{0, 0, 1, 1, 0};
        for (int i = 0; i < 5; i++) begin
            host.set_sel(sv[i]);
            host.send_byte(cd[i], ok);
            check(ok && pins.slct_bit1 === ex[i], "select code");
        end
    endtask
    task automatic t_init();
        saw_rst = 1'b0;
        host.init_pulse(4);
        host.tick(6);
        check(!saw_rst && pins.slct_bit1 === 1'b0, "short init ignored");
        host.init_pulse(16);
        host.tick(6);
        check(saw_rst && prn_reset === 1'b0, "init reset pulse");
        check(pins.slct_bit1 === 1'b1, "select restored");
    endtask
    task automatic t_reverse();
        logic [7:0] v[2] = '{8'h5A, 8'hC3};
        check(pins.logic_high === 1'b0, "logic high forward");
        host.negotiate(EXT_NIBBLE, ok);
        check(ok && pins.logic_high === 1'b1 && pins.slct_bit1 === 1'b1, "negotiation");
        for (int i = 0; i < 2; i++) begin
            rev_data <= 8'h5A ^ 8'(153 * i);
            rev_valid <= 1'b1;
            host.read_byte(b, ok);
            check(ok && b === v[i], "nibble byte");
        end
        check(n_taken == 2, "reverse bytes taken");
        host.leave();
        check(pins.logic_high === 1'b0 && pins.ack_ptr_clk === 1'b1, "back forward");
        host.negotiate(8'h01, ok);
        check(ok && pins.slct_bit1 === 1'b0, "unsupported mode refused");
        host.leave();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {resetn, paper_out, prn_error, prn_offline, prn_ready, rev_valid} = 6'h00;
        rev_data = 8'h00;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        host.tick(4);
        t_status();
        t_fifo();
        t_select();
        t_init();
        t_reverse();
        close_out();
    end
    initial begin
        #240000;
        num_errors++;
        $display("mismatch at %0t: timeout", $time);
        close_out();
    end
endmodule
